//--- pkg/gsms_defines.svh
// constants of the gas sensor measurement sequencer
`ifndef GSMS_DEFINES_SVH
`define GSMS_DEFINES_SVH

// clock rate in MHz (period 8 ns)
`define GSMS_CLK_MHZ 125
// nominal phase lengths in microseconds
`define GSMS_ACTIVE_US 1000
`define GSMS_SLEEP_US 5000
// phase lengths in clock cycles
`define GSMS_ACTIVE_CYC (`GSMS_ACTIVE_US * `GSMS_CLK_MHZ)
`define GSMS_SLEEP_CYC (`GSMS_SLEEP_US * `GSMS_CLK_MHZ)
// result words written back at the end of the active phase
`define GSMS_RESULT_WORDS 8
`define GSMS_ADC_WIDTH 16
// heater target during the active phase
`define GSMS_HEATER_LEVEL 8'h80
// status field positions
`define GSMS_STAT_RUN_BIT 7
`define GSMS_STAT_CFG_BIT 6
// reset values
`define GSMS_INT_N_RST 1'b1
`define GSMS_CFG_RST 1'b0

`endif

//--- pkg/gsms_pkg.sv
// types of the gas sensor measurement sequencer
package gsms_pkg;

	// measurement sequence states
	typedef enum logic [1:0] {
		GSMS_READY,
		GSMS_ACTIVE,
		GSMS_WRITE,
		GSMS_SLEEP
	} gsms_state_e;

endpackage : gsms_pkg

//--- pkg/gsms_timer_if.sv
// phase timer carrier between sequencer and timer
`timescale 1ns/1ns
interface gsms_timer_if;
	logic load;
	logic [31:0] len;
	logic expire;

	modport ctrl (output load, output len, input expire);
	modport tmr (input load, input len, output expire);
endinterface : gsms_timer_if

//--- verilog/gsms_phase_timer.sv
// down counter timing one sequence phase
`timescale 1ns/1ns
module gsms_phase_timer (
	input wire logic clk,
	input wire logic rst,
	gsms_timer_if.tmr tif
);
	typedef struct packed {
		logic busy;
		logic [31:0] cnt;
	} gsms_tmr_s;

	gsms_tmr_s s_q;
	gsms_tmr_s s_d;

	// a load always wins so a phase can chain straight into the next
	always_comb begin
		s_d = s_q;
		if (tif.load) begin
			s_d.busy = 1'b1;
			s_d.cnt = tif.len - 32'h1;
		end else if (s_q.busy) begin
			if (s_q.cnt == 32'h0)
				s_d.busy = 1'b0;
			else
				s_d.cnt = s_q.cnt - 32'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// expiry marks the last cycle of the phase
	assign tif.expire = s_q.busy && (s_q.cnt == 32'h0);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	short_load_a: assert property (tif.load && tif.len == 32'h1 |=> tif.expire)
		else $error("one cycle phase did not expire");
	// an expiry that is not reloaded must go quiet, else the next phase ends early
	idle_quiet_a: assert property (tif.expire && !tif.load |=> !tif.expire)
		else $error("expiry lasted more than one cycle");
endmodule : gsms_phase_timer

//--- verilog/gsms_top.sv
// gas sensor measurement sequencer, device side
// Summary of operation
// - done pin falls when the active measurement phase finishes.
// - done pin stays low until the next accepted start or a reset, reads notwithstanding.
// - heater target nonzero while active; a sleep phase follows every active phase.
// - status ANDed with the active bit reads zero once measurement completes.
// - reset loses configuration; preparation is needed before measuring again.
`timescale 1ns/1ns
`include "gsms_defines.svh"
module gsms_top import gsms_pkg::*; #(
	parameter int ACTIVE_CYC = `GSMS_ACTIVE_CYC,
	parameter int SLEEP_CYC = `GSMS_SLEEP_CYC,
	parameter int RESULT_WORDS = `GSMS_RESULT_WORDS,
	parameter int ADC_WIDTH = `GSMS_ADC_WIDTH,
	parameter logic [7:0] HEATER_LEVEL = `GSMS_HEATER_LEVEL,
	localparam int IW = $clog2(RESULT_WORDS)
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic PREPARE,
	input wire logic START,
	input wire logic [ADC_WIDTH-1:0] ADC_IN,
	input wire logic RES_RD,
	input wire logic [IW-1:0] RES_IDX,
	output logic INT_N,
	output logic [7:0] HEATER_TGT,
	output logic [7:0] STATUS,
	output logic [ADC_WIDTH-1:0] RES_DATA,
	output logic RES_VLD,
	output logic ERR_CONFLICT
);
	// refuse settings the sequencer cannot serve
	if (ACTIVE_CYC < 1 || SLEEP_CYC < 1 || RESULT_WORDS < 2 || ADC_WIDTH < 1
			|| HEATER_LEVEL == 8'h00) begin : g_bad_param
		$error("gsms_top: invalid parameter value");
	end

	typedef struct packed {
		gsms_state_e st;
		logic int_n;
		logic cfg;
		logic [RESULT_WORDS-1:0][ADC_WIDTH-1:0] res;
		logic [IW-1:0] wr_idx;
		logic [ADC_WIDTH-1:0] rdata;
		logic rvld;
		logic err;
	} gsms_state_s;

	localparam gsms_state_s RST_VAL = '{
		st: GSMS_READY,
		int_n: `GSMS_INT_N_RST,
		cfg: `GSMS_CFG_RST,
		default: '0
	};

	// phase is running while heated or writing back results
	function automatic logic gsms_running(input gsms_state_e st);
		return (st == GSMS_ACTIVE) || (st == GSMS_WRITE);
	endfunction : gsms_running

	gsms_state_s s_q;
	gsms_state_s s_d;
	logic accept;
	gsms_timer_if tif ();

	gsms_phase_timer u_timer (
		.clk(MCLK),
		.rst(RESET),
		.tif(tif)
	);

	// sequence control, result write-back and result reads
	always_comb begin
		s_d = s_q;
		s_d.rvld = 1'b0;
		s_d.err = 1'b0;
		tif.load = 1'b0;
		tif.len = 32'(ACTIVE_CYC);
		// only a configured, idle sequencer takes a start
		accept = START && s_q.cfg && (s_q.st == GSMS_READY);
		if (PREPARE)
			s_d.cfg = 1'b1;
		case (s_q.st)
			GSMS_READY: begin
				if (accept) begin
					s_d.st = GSMS_ACTIVE;
					s_d.int_n = 1'b1;
					tif.load = 1'b1;
					tif.len = 32'(ACTIVE_CYC);
				end
			end
			GSMS_ACTIVE: begin
				if (tif.expire) begin
					s_d.st = GSMS_WRITE;
					s_d.wr_idx = '0;
					tif.load = 1'b1;
					tif.len = 32'(RESULT_WORDS);
				end
			end
			GSMS_WRITE: begin
				s_d.res[s_q.wr_idx] = ADC_IN;
				s_d.wr_idx = IW'(s_q.wr_idx + 1'b1);
				if (tif.expire) begin
					s_d.st = GSMS_SLEEP;
					s_d.int_n = 1'b0;
					tif.load = 1'b1;
					tif.len = 32'(SLEEP_CYC);
				end
			end
			GSMS_SLEEP: begin
				// done pin stays low here and in ready
				if (tif.expire)
					s_d.st = GSMS_READY;
			end
			default: begin
				s_d.st = GSMS_READY;
			end
		endcase
		// reads are always answered; during write-back the word may be torn
		if (RES_RD) begin
			s_d.rvld = 1'b1;
			s_d.err = (s_q.st == GSMS_WRITE);
			if (32'(RES_IDX) < RESULT_WORDS)
				s_d.rdata = s_q.res[RES_IDX];
			else
				s_d.rdata = '0;
		end
	end

	// reset drops configuration
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET)
			s_q <= RST_VAL;
		else
			s_q <= s_d;
	end

	// outputs from state flip-flops
	assign INT_N = s_q.int_n;
	assign HEATER_TGT = gsms_running(s_q.st) ? HEATER_LEVEL : 8'h00;
	always_comb begin
		STATUS = 8'h00;
		STATUS[`GSMS_STAT_RUN_BIT] = gsms_running(s_q.st);
		STATUS[`GSMS_STAT_CFG_BIT] = s_q.cfg;
	end
	assign RES_DATA = s_q.rdata;
	assign RES_VLD = s_q.rvld;
	assign ERR_CONFLICT = s_q.err;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	int_fall_a: assert property (s_q.st == GSMS_WRITE && tif.expire |=> !INT_N)
		else $error("done pin did not fall at end of active phase");
	int_cause_a: assert property ($fell(INT_N) |-> $past(s_q.st) == GSMS_WRITE)
		else $error("done pin fell outside end of measurement");
	int_hold_a: assert property (!INT_N && !accept |=> !INT_N)
		else $error("done pin rose without a start");
	int_rise_a: assert property ($rose(INT_N) |-> $past(START) && $past(s_q.cfg))
		else $error("done pin rose without accepted start");
	heater_on_a: assert property (accept |=> HEATER_TGT == HEATER_LEVEL && INT_N)
		else $error("heater target not set in active phase");
	sleep_follow_a: assert property (s_q.st == GSMS_WRITE && tif.expire
			|=> s_q.st == GSMS_SLEEP && HEATER_TGT == 8'h00)
		else $error("sleep phase did not follow active phase");
	run_clear_a: assert property ($fell(STATUS[`GSMS_STAT_RUN_BIT]) |-> !INT_N)
		else $error("active bit cleared without done indication");
	run_start_a: assert property ($rose(STATUS[`GSMS_STAT_RUN_BIT])
			|-> $past(START) && $past(s_q.cfg))
		else $error("sequencer ran without accepted start");
	no_cfg_a: assert property (!STATUS[`GSMS_STAT_CFG_BIT] && !PREPARE && START
			&& !STATUS[`GSMS_STAT_RUN_BIT] |=> !STATUS[`GSMS_STAT_RUN_BIT])
		else $error("start accepted without configuration");
	conflict_a: assert property (RES_RD && s_q.st == GSMS_WRITE
			|=> RES_VLD && ERR_CONFLICT)
		else $error("read during write-back not flagged");
	read_ok_a: assert property (RES_RD && s_q.st != GSMS_WRITE
			|=> RES_VLD && !ERR_CONFLICT)
		else $error("clean read flagged or unanswered");
endmodule : gsms_top

//--- bench/gsms_host_model.sv
// host-side model: start requests and a counting sample stream
`timescale 1ns/1ns
module gsms_host_model (
	input wire logic clk,
	input wire logic go,
	output logic start,
	output logic [15:0] adc
);
	// one start per request, never on its own; samples restart at every start, accepted or not
	always @(posedge clk) begin
		start <= go;
		adc <= start ? 16'h0001 : adc + 16'h0001;
	end
	initial begin
		start = 1'b0;
		adc = 16'h0000;
	end
endmodule : gsms_host_model

//--- bench/tb_top.sv
// self-checking bench of the measurement sequencer
`timescale 1ns/1ns
module tb_top;
	localparam int ACT = 20;
	localparam int SLP = 30;
	localparam int RW = 8;
	// host measurement interval: one cycle of slack over the shortest legal restart
	localparam int IVL = ACT + RW + SLP + 2;
	logic mclk, reset, prepare, start, res_rd, go, int_n, res_vld, err_conflict;
	logic [15:0] adc_in, res_data;
	logic [2:0] res_idx;
	logic [7:0] heater_tgt, status;
	int failures, check_count, cycles;

	gsms_top #(.ACTIVE_CYC(ACT), .SLEEP_CYC(SLP), .RESULT_WORDS(RW), .HEATER_LEVEL(8'h80))
	gsms_top_inst (.MCLK(mclk), .RESET(reset), .PREPARE(prepare), .START(start),
		.ADC_IN(adc_in), .RES_RD(res_rd), .RES_IDX(res_idx), .INT_N(int_n),
		.HEATER_TGT(heater_tgt), .STATUS(status), .RES_DATA(res_data),
		.RES_VLD(res_vld), .ERR_CONFLICT(err_conflict));
	gsms_host_model gsms_host_model_inst (.clk(mclk), .go(go), .start(start), .adc(adc_in));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (exp !== got) begin
			failures++;
			$display("mismatch %s exp %h got %h", name, exp, got);
		end
	endtask : chk

	task automatic conclude();
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// ask for a start, then give it a few cycles to show as busy
	task automatic launch();
		int n;
		n = 0;
		@(posedge mclk) go <= 1'b1;
		@(posedge mclk) go <= 1'b0;
		while (status[7] !== 1'b1 && n < 10) begin
			@(negedge mclk);
			n++;
		end
	endtask : launch

	task automatic configure();
		@(posedge mclk) prepare <= 1'b1;
		@(posedge mclk) prepare <= 1'b0;
		@(negedge mclk);
		chk("configured", 1, status[6]);
	endtask : configure

	task automatic rd(input logic [2:0] idx);
		@(posedge mclk) begin
			res_rd <= 1'b1;
			res_idx <= idx;
		end
		@(posedge mclk) res_rd <= 1'b0;
		@(negedge mclk);
		chk("res_vld", 1, res_vld);
	endtask : rd

	// cycles from first busy cycle to the done pin falling
	task automatic wait_done(output int n);
		n = 0;
		while (int_n !== 1'b0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_done

	task automatic measure();
		int n;
		launch();
		chk("busy", 1, status[7]);
		chk("heater on", 8'h80, heater_tgt);
		wait_done(n);
		chk("active len", ACT + RW, n);
		chk("busy after", 0, status[7]);
		chk("heater off", 0, heater_tgt);
		launch();
		chk("start in sleep", 0, status[7]);
	endtask : measure

	// every word read after completion is clean; pin stays low meanwhile
	task automatic read_all();
		for (int k = 0; k < RW; k++) begin
			rd(k[2:0]);
			chk("word", ACT + 1 + k, res_data);
			chk("clean", 0, err_conflict);
		end
		chk("pin held", 0, int_n);
	endtask : read_all

	// one interval timer paces the host; results are read just before the next start
	task automatic paced();
		int t;
		int prev;
		prev = 0;
		for (int m = 0; m < 3; m++) begin
			launch();
			chk("paced start", 1, status[7]);
			if (m > 0)
				chk("interval", IVL, cycles - prev);
			prev = cycles;
			t = 0;
			// done edge or own timer, whichever first
			while (int_n !== 1'b0 && t < IVL) begin
				@(negedge mclk);
				t++;
			end
			chk("run bit", 8'h00, status & 8'h80);
			while (t < IVL - 5) begin
				@(negedge mclk);
				t++;
			end
			rd(3'h0);
			chk("paced word", ACT + 1, res_data);
		end
	endtask : paced

	// a read landing in write-back is flagged
	task automatic conflict();
		int n;
		launch();
		repeat (ACT) @(posedge mclk);
		rd(3'h3);
		chk("conflict", 1, err_conflict);
		wait_done(n);
		read_all();
	endtask : conflict

	// reset lands in the middle of an active phase
	task automatic reset_mid();
		launch();
		@(posedge mclk) reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		chk("int_n rst", 1, int_n);
		chk("status rst", 0, status);
		chk("heater rst", 0, heater_tgt);
		rd(3'h0);
		chk("word rst", 0, res_data);
		launch();
		chk("unconfigured", 0, status[7]);
		configure();
		measure();
	endtask : reset_mid

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// hang guard; a full run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		reset = 1'b1;
		prepare = 1'b0;
		res_rd = 1'b0;
		go = 1'b0;
		res_idx = 3'h0;
		failures = 0;
		check_count = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		chk("int_n idle", 1, int_n);
		launch();
		chk("no prepare", 0, status[7]);
		configure();
		measure();
		read_all();
		repeat (SLP) @(posedge mclk);
		paced();
		repeat (SLP) @(posedge mclk);
		conflict();
		repeat (SLP) @(posedge mclk);
		reset_mid();
		conclude();
	end
endmodule : tb_top
